// ==== hw/core_debug_breakpoint_unit.sv ====
// debug state, breakpoint and watchpoint logic of one processor tile
`timescale 1ns/100ps
`default_nettype none
module core_debug_breakpoint_unit
  import debug_break_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic debug_mode_i,
  input wire logic host_request_i,
  input wire call_type call_i,
  input wire debug_entry_type entry_i,
  input wire exec_type exec_i,
  input wire mem_access_type mem_i,
  input wire resource_access_type res_i,
  output logic debug_irq_o,
  output logic [7:0] thread_stop_o,
  output logic [7:0] thread_select_o,
  output logic [4:0] reg_index_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = din[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic unit_ctrl_type to_ctrl(input logic [31:0] w);
    unit_ctrl_type c;
    c.threads = w[CTRL_THREAD_LSB +: 8];
    c.load = w[CTRL_LOAD_BIT];
    c.cond = w[CTRL_COND_BIT];
    c.enable = w[CTRL_ENABLE_BIT];
    return c;
  endfunction

  function automatic logic [31:0] from_ctrl(input unit_ctrl_type c);
    logic [31:0] w;
    w = RESET_WORD;
    w[CTRL_THREAD_LSB +: 8] = c.threads;
    w[CTRL_LOAD_BIT] = c.load;
    w[CTRL_COND_BIT] = c.cond;
    w[CTRL_ENABLE_BIT] = c.enable;
    return w;
  endfunction

  function automatic logic allowed(input unit_ctrl_type c, input logic [2:0] t);
    return c.enable && c.threads[t];
  endfunction

  function automatic logic [1:0] lowest(input logic [3:0] hits);
    logic [1:0] n;
    n = 2'h0;
    for (int i = NUM_UNITS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        n = 2'(i);
      end
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [31:0] saved_stack_pointer;
  logic [7:0] remote_read_thread_field;
  logic [4:0] remote_read_index_field;
  logic [2:0] cause_code_field;
  logic [7:0] cause_thread;
  logic [1:0] cause_unit;
  logic [31:0] debug_event_data;
  logic [7:0] thread_run_suppress;
  logic [31:0] debugger_scratch [NUM_SCRATCH];
  logic [31:0] instr_break_address [NUM_UNITS];
  unit_ctrl_type instr_break_control [NUM_UNITS];
  logic [31:0] data_watch_first_address [NUM_UNITS];
  logic [31:0] data_watch_second_address [NUM_UNITS];
  unit_ctrl_type data_watch_control [NUM_UNITS];
  logic [31:0] resource_watch_mask [NUM_UNITS];
  logic [31:0] resource_watch_value [NUM_UNITS];
  unit_ctrl_type resource_watch_control [NUM_UNITS];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] idx;
  logic bus_req;
  logic wr;
  logic [1:0] sub;
  logic [31:0] next_dat;

  assign idx = adr_i[9:2];
  assign sub = idx[1:0];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr = bus_req && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= RESET_WORD;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? next_dat : RESET_WORD;
    end
  end

  // reserved bits and unmapped words read as zero
  always_comb begin
    next_dat = RESET_WORD;
    if (idx == IDX_SAVED_SP) begin
      next_dat = saved_stack_pointer;
    end else if (idx == IDX_THREAD_SELECT) begin
      next_dat[7:0] = remote_read_thread_field;
    end else if (idx == IDX_REG_INDEX) begin
      next_dat[4:0] = remote_read_index_field;
    end else if (idx == IDX_CAUSE) begin
      next_dat[CAUSE_LSB +: 3] = cause_code_field;
      next_dat[CAUSE_THREAD_LSB +: 8] = cause_thread;
      next_dat[CAUSE_UNIT_LSB +: 2] = cause_unit;
    end else if (idx == IDX_EVENT_DATA) begin
      next_dat = debug_event_data;
    end else if (idx == IDX_RUN_SUPPRESS) begin
      next_dat[7:0] = thread_run_suppress;
    end else if (idx[7:3] == IDX_SCRATCH[7:3]) begin
      next_dat = debugger_scratch[idx[2:0]];
    end else if (idx[7:2] == IDX_INSTR_BREAK_MATCH_VALUE[7:2]) begin
      next_dat = instr_break_address[sub];
    end else if (idx[7:2] == IDX_IBREAK_CTRL[7:2]) begin
      next_dat = from_ctrl(instr_break_control[sub]) & ~32'h0000_0004;
    end else if (idx[7:2] == IDX_DWATCH_FIRST[7:2]) begin
      next_dat = data_watch_first_address[sub];
    end else if (idx[7:2] == IDX_DWATCH_SECOND[7:2]) begin
      next_dat = data_watch_second_address[sub];
    end else if (idx[7:2] == IDX_DWATCH_CTRL[7:2]) begin
      next_dat = from_ctrl(data_watch_control[sub]);
    end else if (idx[7:2] == IDX_RWATCH_MASK[7:2]) begin
      next_dat = resource_watch_mask[sub];
    end else if (idx[7:2] == IDX_RWATCH_VALUE[7:2]) begin
      next_dat = resource_watch_value[sub];
    end else if (idx[7:2] == IDX_RWATCH_CTRL[7:2]) begin
      next_dat = from_ctrl(resource_watch_control[sub]) & ~32'h0000_0004;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match logic

  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  always_comb begin
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      // equality, or inequality when the condition bit is set
      ib_hit[i] = exec_i.valid && allowed(instr_break_control[i], exec_i.thread) &&
                  ((exec_i.pc == instr_break_address[i]) != instr_break_control[i].cond);
      a = mem_i.addr == data_watch_first_address[i];
      b = mem_i.addr == data_watch_second_address[i];
      dw_hit[i] = mem_i.valid && allowed(data_watch_control[i], mem_i.thread) &&
                  (!mem_i.load || data_watch_control[i].load) &&
                  (data_watch_control[i].cond ? (a || b) : (a && b));
      // condition A: masked equal, B: masked differ
      a = ((res_i.id ^ resource_watch_value[i]) & resource_watch_mask[i]) == RESET_WORD;
      rw_hit[i] = res_i.valid && allowed(resource_watch_control[i], res_i.thread) &&
                  (resource_watch_control[i].cond ? !a : a);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event capture, host first then call, ibreak, dwatch, rwatch

  logic event_fire;
  logic [2:0] next_cause;
  logic [7:0] next_thread;
  logic [1:0] next_unit;
  logic [31:0] next_data;
  logic data_load;

  always_comb begin
    event_fire = !debug_mode_i;
    next_cause = CAUSE_NONE;
    next_thread = 8'h00;
    next_unit = 2'h0;
    next_data = RESET_WORD;
    data_load = 1'b0;
    if (host_request_i) begin
      next_cause = CAUSE_HOST;
    end else if (call_i.valid) begin
      next_cause = CAUSE_CALL;
      next_thread = {5'h00, call_i.thread};
    end else if (|ib_hit) begin
      next_cause = CAUSE_IBREAK;
      next_thread = {5'h00, exec_i.thread};
      next_unit = lowest(ib_hit);
    end else if (|dw_hit) begin
      next_cause = CAUSE_DWATCH;
      next_thread = {5'h00, mem_i.thread};
      next_unit = lowest(dw_hit);
      next_data = mem_i.addr;
      data_load = 1'b1;
    end else if (|rw_hit) begin
      next_cause = CAUSE_RWATCH;
      next_thread = {5'h00, res_i.thread};
      next_unit = lowest(rw_hit);
      next_data = res_i.id;
      data_load = 1'b1;
    end else begin
      event_fire = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_irq_o <= 1'b0;
    end else begin
      debug_irq_o <= event_fire;
    end
  end

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_code_field <= CAUSE_NONE;
      cause_thread <= 8'h00;
      cause_unit <= 2'h0;
    end else if (event_fire) begin
      cause_code_field <= next_cause;
      cause_thread <= next_thread;
      cause_unit <= next_unit;
    end else if (wr && idx == IDX_CAUSE) begin
      if (sel_i[0]) cause_code_field <= dat_i[CAUSE_LSB +: 3];
      if (sel_i[1]) cause_thread <= dat_i[CAUSE_THREAD_LSB +: 8];
      if (sel_i[2]) cause_unit <= dat_i[CAUSE_UNIT_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_event_data <= RESET_WORD;
    end else if (event_fire && data_load) begin
      debug_event_data <= next_data;
    end else if (wr && idx == IDX_EVENT_DATA) begin
      debug_event_data <= merge(debug_event_data, dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      saved_stack_pointer <= RESET_WORD;
    end else if (entry_i.valid) begin
      saved_stack_pointer <= entry_i.sp;
    end else if (wr && idx == IDX_SAVED_SP) begin
      saved_stack_pointer <= merge(saved_stack_pointer, dat_i, sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain software registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_read_thread_field <= 8'h00;
      remote_read_index_field <= 5'h00;
      thread_run_suppress <= 8'h00;
    end else if (wr && sel_i[0]) begin
      if (idx == IDX_THREAD_SELECT) remote_read_thread_field <= dat_i[7:0];
      if (idx == IDX_REG_INDEX) remote_read_index_field <= dat_i[4:0];
      if (idx == IDX_RUN_SUPPRESS) thread_run_suppress <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thread_stop_o <= 8'h00;
      thread_select_o <= 8'h00;
      reg_index_o <= 5'h00;
    end else begin
      thread_stop_o <= debug_mode_i ? 8'h00 : thread_run_suppress;
      thread_select_o <= remote_read_thread_field;
      reg_index_o <= remote_read_index_field;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SCRATCH; i++) begin
        debugger_scratch[i] <= RESET_WORD;
      end
    end else if (wr && idx[7:3] == IDX_SCRATCH[7:3]) begin
      debugger_scratch[idx[2:0]] <= merge(debugger_scratch[idx[2:0]], dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        instr_break_address[i] <= RESET_WORD;
        data_watch_first_address[i] <= RESET_WORD;
        data_watch_second_address[i] <= RESET_WORD;
        resource_watch_mask[i] <= RESET_WORD;
        resource_watch_value[i] <= RESET_WORD;
      end
    end else if (wr) begin
      unique case (idx[7:2])
        IDX_INSTR_BREAK_MATCH_VALUE[7:2]: begin
          instr_break_address[sub] <= merge(instr_break_address[sub], dat_i, sel_i);
        end
        IDX_DWATCH_FIRST[7:2]: begin
          data_watch_first_address[sub] <= merge(data_watch_first_address[sub], dat_i, sel_i);
        end
        IDX_DWATCH_SECOND[7:2]: begin
          data_watch_second_address[sub] <= merge(data_watch_second_address[sub], dat_i, sel_i);
        end
        IDX_RWATCH_MASK[7:2]: begin
          resource_watch_mask[sub] <= merge(resource_watch_mask[sub], dat_i, sel_i);
        end
        IDX_RWATCH_VALUE[7:2]: begin
          resource_watch_value[sub] <= merge(resource_watch_value[sub], dat_i, sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // control words; the load bit exists only on data watchpoints
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        instr_break_control[i] <= '0;
        data_watch_control[i] <= '0;
        resource_watch_control[i] <= '0;
      end
    end else if (wr) begin
      if (idx[7:2] == IDX_IBREAK_CTRL[7:2]) begin
        instr_break_control[sub] <= to_ctrl(merge(from_ctrl(instr_break_control[sub]), dat_i, sel_i));
        instr_break_control[sub].load <= 1'b0;
      end
      if (idx[7:2] == IDX_DWATCH_CTRL[7:2]) begin
        data_watch_control[sub] <= to_ctrl(merge(from_ctrl(data_watch_control[sub]), dat_i, sel_i));
      end
      if (idx[7:2] == IDX_RWATCH_CTRL[7:2]) begin
        resource_watch_control[sub] <= to_ctrl(merge(from_ctrl(resource_watch_control[sub]), dat_i, sel_i));
        resource_watch_control[sub].load <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== shared/debug_break_pkg.sv ====
// constants, field layouts and carrier types of the debug breakpoint unit
package debug_break_pkg;
  localparam int unsigned NUM_THREADS = 8;
  localparam int unsigned NUM_UNITS = 4;
  localparam int unsigned NUM_SCRATCH = 8;

  // word indices; byte address is four times the index
  localparam logic [7:0] IDX_SAVED_SP = 8'h12;
  localparam logic [7:0] IDX_THREAD_SELECT = 8'h13;
  localparam logic [7:0] IDX_REG_INDEX = 8'h14;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_EVENT_DATA = 8'h16;
  localparam logic [7:0] IDX_RUN_SUPPRESS = 8'h18;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;
  localparam logic [7:0] IDX_INSTR_BREAK_MATCH_VALUE = 8'h30;
  localparam logic [7:0] IDX_IBREAK_CTRL = 8'h40;
  localparam logic [7:0] IDX_DWATCH_FIRST = 8'h50;
  localparam logic [7:0] IDX_DWATCH_SECOND = 8'h60;
  localparam logic [7:0] IDX_DWATCH_CTRL = 8'h70;
  localparam logic [7:0] IDX_RWATCH_MASK = 8'h80;
  localparam logic [7:0] IDX_RWATCH_VALUE = 8'h90;
  localparam logic [7:0] IDX_RWATCH_CTRL = 8'h9c;

  // field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_COND_BIT = 1;
  localparam int unsigned CTRL_LOAD_BIT = 2;
  localparam int unsigned CTRL_THREAD_LSB = 16;
  localparam int unsigned CAUSE_LSB = 0;
  localparam int unsigned CAUSE_THREAD_LSB = 8;
  localparam int unsigned CAUSE_UNIT_LSB = 16;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_CALL = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  typedef struct packed {
    logic [7:0] threads;
    logic load;
    logic cond;
    logic enable;
  } unit_ctrl_type;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] pc;
  } exec_type;

  typedef struct packed {
    logic valid;
    logic load;
    logic [2:0] thread;
    logic [31:0] addr;
  } mem_access_type;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] id;
  } resource_access_type;

  typedef struct packed {
    logic valid;
    logic [31:0] sp;
  } debug_entry_type;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
  } call_type;
endpackage

// ==== testbench/core_debug_breakpoint_unit_assertions.sv ====
// port checker for the debug breakpoint unit
`timescale 1ns/100ps
`default_nettype none
module core_debug_breakpoint_unit_assertions
  import debug_break_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic debug_mode_i,
  input wire logic host_request_i,
  input wire call_type call_i,
  input wire exec_type exec_i,
  input wire mem_access_type mem_i,
  input wire resource_access_type res_i,
  input wire logic debug_irq_o,
  input wire logic [7:0] thread_stop_o,
  input wire logic [7:0] thread_select_o,
  input wire logic [4:0] reg_index_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_host_raises_irq: assert property (host_request_i && !debug_mode_i |=> debug_irq_o)
    else $error("host request gave no debug interrupt");
  a_mode_blocks_irq: assert property (debug_mode_i |=> !debug_irq_o)
    else $error("event taken in debug mode");
  a_irq_has_cause: assert property (debug_irq_o |-> $past(!debug_mode_i) &&
    $past(host_request_i || call_i.valid || exec_i.valid || mem_i.valid || res_i.valid))
    else $error("debug interrupt without an event");
  a_stop_in_debug: assert property (debug_mode_i |=> thread_stop_o == 8'h00)
    else $error("threads stopped while in debug mode");
  a_select_copy: assert property (cyc_i && stb_i && !ack_o && we_i && sel_i[0] &&
    adr_i[9:2] == IDX_THREAD_SELECT |=> ##1 thread_select_o == $past(dat_i[7:0], 2))
    else $error("thread selector output not updated");
  a_index_copy: assert property (cyc_i && stb_i && !ack_o && we_i && sel_i[0] &&
    adr_i[9:2] == IDX_REG_INDEX |=> ##1 reg_index_o == $past(dat_i[4:0], 2))
    else $error("register index output not updated");
endmodule
bind core_debug_breakpoint_unit core_debug_breakpoint_unit_assertions chk_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .debug_mode_i(debug_mode_i),
  .host_request_i(host_request_i), .call_i(call_i), .exec_i(exec_i), .mem_i(mem_i),
  .res_i(res_i), .debug_irq_o(debug_irq_o), .thread_stop_o(thread_stop_o),
  .thread_select_o(thread_select_o), .reg_index_o(reg_index_o));
`default_nettype wire

// ==== testbench/debug_host_model.sv ====
// debugger side: classic single-cycle bus master
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // request held until ack is sampled high
  task automatic access(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_core_debug_breakpoint_unit.sv ====
// self-checking bench of the debug breakpoint unit
`timescale 1ns/100ps
`default_nettype none
module test_core_debug_breakpoint_unit;
  import debug_break_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, debug_irq_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, v;
  logic debug_mode_i = 1'b0;
  logic host_request_i = 1'b0;
  call_type call_i = '0;
  debug_entry_type entry_i = '0;
  exec_type exec_i = '0;
  mem_access_type mem_i = '0;
  resource_access_type res_i = '0;
  logic [7:0] thread_stop_o, thread_select_o;
  logic [4:0] reg_index_o;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  core_debug_breakpoint_unit core_debug_breakpoint_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .debug_mode_i(debug_mode_i), .host_request_i(host_request_i),
    .call_i(call_i), .entry_i(entry_i), .exec_i(exec_i), .mem_i(mem_i), .res_i(res_i),
    .debug_irq_o(debug_irq_o), .thread_stop_o(thread_stop_o),
    .thread_select_o(thread_select_o), .reg_index_o(reg_index_o));
  debug_host_model debug_host_model_inst (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    debug_host_model_inst.access(1'b1, idx, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    debug_host_model_inst.access(1'b0, idx, 32'h0000_0000, 4'hf);
  endtask
  // drop every event strobe, then look at the interrupt pulse
  task automatic irq(input logic e);
    @(posedge clk_i);
    host_request_i <= 1'b0;
    call_i.valid <= 1'b0;
    entry_i.valid <= 1'b0;
    exec_i.valid <= 1'b0;
    mem_i.valid <= 1'b0;
    res_i.valid <= 1'b0;
    #1;
    chk("debug_irq_o", {31'h0, e}, {31'h0, debug_irq_o});
    // hand back on a rising edge so later stimulus stays edge aligned
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 32'h0, 32'hffff_ffff);
      end else begin
        chk("dat_o", exp_q.pop_front(), dat_o);
      end
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(91637));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_CAUSE, 32'h0);
    rd(IDX_IBREAK_CTRL, 32'h0);
    rd(IDX_DWATCH_CTRL + 8'h3, 32'h0);
    rd(8'hff, 32'h0);
    wr(IDX_THREAD_SELECT, 32'hffff_ffff);
    rd(IDX_THREAD_SELECT, 32'h0000_00ff);
    chk("thread_select_o", 32'h0000_00ff, {24'h0, thread_select_o});
    wr(IDX_REG_INDEX, 32'hffff_ffff);
    rd(IDX_REG_INDEX, 32'h0000_001f);
    chk("reg_index_o", 32'h0000_001f, {27'h0, reg_index_o});
    $display("test operands done");
    v = $urandom();
    @(posedge clk_i);
    entry_i <= '{1'b1, v};
    irq(1'b0);
    rd(IDX_SAVED_SP, v);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      wr(IDX_SCRATCH + 8'(i), v);
      rd(IDX_SCRATCH + 8'(i), v);
    end
    // single byte lane write must leave the other lanes alone
    debug_host_model_inst.access(1'b1, IDX_SCRATCH + 8'h7, 32'hffff_ffff, 4'h2);
    rd(IDX_SCRATCH + 8'h7, (v & 32'hffff_00ff) | 32'h0000_ff00);
    wr(IDX_RUN_SUPPRESS, 32'hffff_ff5a);
    rd(IDX_RUN_SUPPRESS, 32'h0000_005a);
    chk("thread_stop_o", 32'h5a, {24'h0, thread_stop_o});
    debug_mode_i <= 1'b1;
    @(posedge clk_i);
    host_request_i <= 1'b1;
    irq(1'b0);
    chk("thread_stop_o", 32'h0, {24'h0, thread_stop_o});
    debug_mode_i <= 1'b0;
    $display("test state done");
    @(posedge clk_i);
    host_request_i <= 1'b1;
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0000_0001);
    @(posedge clk_i);
    call_i <= '{1'b1, 3'd5};
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0000_0502);
    $display("test host and call done");
    v = $urandom() & 32'hffff_fff0;
    wr(IDX_INSTR_BREAK_MATCH_VALUE, v);
    wr(IDX_IBREAK_CTRL, 32'h00ff_0000);
    wr(IDX_INSTR_BREAK_MATCH_VALUE + 8'h2, v);
    wr(IDX_IBREAK_CTRL + 8'h2, 32'h0008_0001);
    @(posedge clk_i);
    exec_i <= '{1'b1, 3'd3, v};
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0002_0303);
    wr(IDX_INSTR_BREAK_MATCH_VALUE + 8'h1, v);
    wr(IDX_IBREAK_CTRL + 8'h1, 32'hff00_fff3);
    rd(IDX_IBREAK_CTRL + 8'h1, 32'h0000_0003);
    wr(IDX_IBREAK_CTRL + 8'h1, 32'h00ff_0003);
    @(posedge clk_i);
    exec_i <= '{1'b1, 3'd6, v + 32'h4};
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0001_0603);
    @(posedge clk_i);
    exec_i <= '{1'b1, 3'd4, v};
    irq(1'b0);
    $display("test instruction breaks done");
    wr(IDX_DWATCH_FIRST, 32'h0000_1000);
    wr(IDX_DWATCH_SECOND, 32'h0000_2000);
    wr(IDX_DWATCH_CTRL, 32'h00ff_0003);
    @(posedge clk_i);
    mem_i <= '{1'b1, 1'b0, 3'd2, 32'h0000_2000};
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0000_0204);
    rd(IDX_EVENT_DATA, 32'h0000_2000);
    @(posedge clk_i);
    mem_i <= '{1'b1, 1'b1, 3'd2, 32'h0000_1000};
    irq(1'b0);
    wr(IDX_DWATCH_CTRL, 32'h00ff_0007);
    @(posedge clk_i);
    mem_i <= '{1'b1, 1'b1, 3'd1, 32'h0000_1000};
    irq(1'b1);
    rd(IDX_EVENT_DATA, 32'h0000_1000);
    wr(IDX_DWATCH_CTRL, 32'h00ff_0005);
    @(posedge clk_i);
    mem_i <= '{1'b1, 1'b0, 3'd1, 32'h0000_1000};
    irq(1'b0);
    wr(IDX_DWATCH_CTRL, 32'h00fe_0003);
    @(posedge clk_i);
    mem_i <= '{1'b1, 1'b0, 3'd0, 32'h0000_1000};
    irq(1'b0);
    $display("test data watches done");
    wr(IDX_RWATCH_MASK + 8'h3, 32'hffff_ff00);
    rd(IDX_RWATCH_MASK + 8'h3, 32'hffff_ff00);
    wr(IDX_RWATCH_VALUE + 8'h3, 32'h1234_5600);
    rd(IDX_RWATCH_VALUE + 8'h3, 32'h1234_5600);
    wr(IDX_RWATCH_CTRL + 8'h3, 32'h00ff_0001);
    @(posedge clk_i);
    res_i <= '{1'b1, 3'd7, 32'h1234_56ab};
    irq(1'b1);
    rd(IDX_CAUSE, 32'h0003_0705);
    rd(IDX_EVENT_DATA, 32'h1234_56ab);
    @(posedge clk_i);
    res_i <= '{1'b1, 3'd7, 32'h1234_57ab};
    irq(1'b0);
    $display("test resource watches done");
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule
`default_nettype wire
